// ---- inc/trr_pkg.sv ----
package trr_pkg;

    // system clock
    localparam int TRR_CLK_HZ = 25_000_000;
    localparam int TRR_CYC_PER_MS = TRR_CLK_HZ / 1000;

    // conversion times, in ms, and the derived cycle counts
    localparam int TRR_LOCAL_CONV_MS = 12;
    localparam int TRR_REMOTE_CONV_MS = 38;
    localparam int TRR_LOCAL_CONV_CYC = TRR_LOCAL_CONV_MS * TRR_CYC_PER_MS;
    localparam int TRR_REMOTE_CONV_CYC = TRR_REMOTE_CONV_MS * TRR_CYC_PER_MS;
    localparam int TRR_CONV_CNT_W = 20;

    // command codes
    localparam logic [7:0] TRR_CODE_LOCAL = 8'h00;
    localparam logic [7:0] TRR_CODE_REMOTE_ONE = 8'h01;
    localparam logic [7:0] TRR_CODE_REMOTE_TWO = 8'h02;
    localparam logic [7:0] TRR_CODE_OFFSET = 8'hE0;
    localparam logic [7:0] TRR_CODE_IGNORE_LO = 8'h03;
    localparam logic [7:0] TRR_CODE_IGNORE_HI = 8'hDF;
    localparam logic [7:0] TRR_CODE_RESV_LO = 8'hE2;
    localparam logic [7:0] TRR_CODE_RESV_HI = 8'hEE;
    localparam logic [7:0] TRR_ALL_TEMPS_LEN = 8'h04;

    // channel indices of the round robin
    localparam logic [1:0] TRR_CHAN_LOCAL = 2'h0;
    localparam logic [1:0] TRR_CHAN_REMOTE_ONE = 2'h1;
    localparam logic [1:0] TRR_CHAN_REMOTE_TWO = 2'h2;

    // data format: 1 lsb = 1/64 degree
    localparam logic [15:0] TRR_FAULT_CODE = 16'h8000;
    localparam logic [15:0] TRR_RESULT_RST = 16'h0000;
    localparam logic [15:0] TRR_OFFSET_RST = 16'h0000;
    localparam logic [15:0] TRR_OFFSET_MAX = 16'h2000;
    localparam logic [15:0] TRR_OFFSET_MIN = 16'hE000;
    localparam logic [15:0] TRR_OFFSET_GRAN_MASK = 16'hFFF0;
    localparam logic [15:0] TRR_TEMP_MAX = 16'h7FFF;
    localparam logic [15:0] TRR_TEMP_MIN = 16'h8001;
    localparam logic [7:0] TRR_BYTE_RST = 8'h00;
    localparam logic [47:0] TRR_RESP_RST = 48'h000000000000;

    typedef enum logic [3:0] {
        TRR_DEV_IDLE = 4'b0001,
        TRR_DEV_WRITE = 4'b0010,
        TRR_DEV_READ = 4'b0100,
        TRR_DEV_DONE = 4'b1000
    } trr_dev_state_type;

    typedef enum logic [3:0] {
        TRR_HOST_IDLE = 4'b0001,
        TRR_HOST_CMD = 4'b0010,
        TRR_HOST_WRITE = 4'b0100,
        TRR_HOST_WAIT = 4'b1000
    } trr_host_state_type;

endpackage

// ---- inc/trr_link_if.sv ----
`timescale 1ns/1ns
interface trr_link_if;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [7:0] wr_len;
    logic [7:0] rd_len;
    logic wr_valid;
    logic [7:0] wr_data;
    logic rd_valid;
    logic [7:0] rd_data;
    logic done;
    logic check_ok;

    modport device (
        input cmd_valid, cmd_code, wr_len, rd_len, wr_valid, wr_data,
        output rd_valid, rd_data, done, check_ok
    );
    modport host (
        output cmd_valid, cmd_code, wr_len, rd_len, wr_valid, wr_data,
        input rd_valid, rd_data, done, check_ok
    );
endinterface // trr_link_if

// ---- core/trr_device.sv ----
`timescale 1ns/1ns
module trr_device
    import trr_pkg::*;
#(
    parameter int LOCAL_CONV_CYC = TRR_LOCAL_CONV_CYC,
    parameter int REMOTE_CONV_CYC = TRR_REMOTE_CONV_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // link to the host
    trr_link_if.device link,
    // measurement front end, 1/64 degree units
    input wire logic [15:0] local_meas,
    input wire logic [15:0] remote_one_meas,
    input wire logic [15:0] remote_two_meas,
    input wire logic remote_one_fault,
    input wire logic remote_two_fault,
    input wire logic remote_two_present,
    // conversion status
    output logic [1:0] conv_channel,
    output logic conv_done
);

    trr_dev_state_type state_reg;
    logic [TRR_CONV_CNT_W-1:0] conv_cnt_reg;
    logic [TRR_CONV_CNT_W-1:0] conv_limit;
    logic [1:0] chan_next;
    logic [15:0] result_reg [0:2];
    logic [15:0] snap_reg [0:2];
    logic [15:0] offset_reg;
    logic [15:0] offset_next;
    logic [15:0] meas_sel;
    logic fault_sel;
    logic [15:0] corrected;
    logic [7:0] code_reg;
    logic [7:0] wr_left_reg;
    logic [7:0] rd_left_reg;
    logic [7:0] idx_reg;
    logic [7:0] low_byte_reg;
    logic [15:0] word_sel;
    logic [7:0] byte_sel;
    logic reserved_code;

    // saturating add keeps a large offset from wrapping the sign
    function automatic logic [15:0] sat_add(input logic [15:0] a,
                                            input logic [15:0] b);
        logic [16:0] s;
        s = {a[15], a} + {b[15], b};
        if (s[16] != s[15]) begin
            sat_add = s[16] ? TRR_TEMP_MIN : TRR_TEMP_MAX;
        end else begin
            sat_add = s[15:0];
        end
    endfunction

    // round robin sequencing, remote two only when fitted
    always_comb begin
        conv_limit = (conv_channel == TRR_CHAN_LOCAL) ?
            TRR_CONV_CNT_W'(LOCAL_CONV_CYC - 1) :
            TRR_CONV_CNT_W'(REMOTE_CONV_CYC - 1);
        unique case (conv_channel)
            TRR_CHAN_LOCAL: chan_next = TRR_CHAN_REMOTE_ONE;
            TRR_CHAN_REMOTE_ONE: chan_next = remote_two_present ?
                TRR_CHAN_REMOTE_TWO : TRR_CHAN_LOCAL;
            default: chan_next = TRR_CHAN_LOCAL;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            conv_cnt_reg <= '0;
            conv_channel <= TRR_CHAN_LOCAL;
            conv_done <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            if (conv_cnt_reg >= conv_limit) begin
                conv_cnt_reg <= '0;
                conv_channel <= chan_next;
                conv_done <= 1'b1;
            end else begin
                conv_cnt_reg <= conv_cnt_reg + 1'b1;
            end
        end
    end

    always_comb begin
        unique case (conv_channel)
            TRR_CHAN_LOCAL: begin
                meas_sel = local_meas;
                fault_sel = 1'b0;
            end
            TRR_CHAN_REMOTE_ONE: begin
                meas_sel = remote_one_meas;
                fault_sel = remote_one_fault;
            end
            default: begin
                meas_sel = remote_two_meas;
                fault_sel = remote_two_fault;
            end
        endcase
        // signed 1/64 degree words, offset applied to every channel
        corrected = fault_sel ? TRR_FAULT_CODE :
            sat_add(meas_sel, offset_reg);
    end

    // a whole word is written in one edge, never byte by byte
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            result_reg[0] <= TRR_RESULT_RST;
            result_reg[1] <= TRR_RESULT_RST;
            result_reg[2] <= TRR_RESULT_RST;
        end else if (conv_cnt_reg >= conv_limit) begin
            result_reg[conv_channel] <= corrected;
        end
    end

    // offset: quarter degree steps, clamped to +-128 degrees
    always_comb begin
        offset_next = {link.wr_data, low_byte_reg} &
            TRR_OFFSET_GRAN_MASK;
        if (!offset_next[15] && offset_next > TRR_OFFSET_MAX) begin
            offset_next = TRR_OFFSET_MAX;
        end else if (offset_next[15] && offset_next < TRR_OFFSET_MIN) begin
            offset_next = TRR_OFFSET_MIN;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            offset_reg <= TRR_OFFSET_RST;
        end else if (state_reg == TRR_DEV_WRITE && link.wr_valid &&
                     idx_reg == 8'h01 && code_reg == TRR_CODE_OFFSET) begin
            offset_reg <= offset_next;
        end
    end

    // read data path
    always_comb begin
        word_sel = TRR_RESULT_RST;
        unique case (code_reg)
            TRR_CODE_LOCAL: begin
                if (idx_reg[7:1] < 7'h03) begin
                    word_sel = snap_reg[idx_reg[2:1]];
                end
            end
            TRR_CODE_REMOTE_ONE: begin
                if (idx_reg[7:1] == 7'h00) begin
                    word_sel = snap_reg[1];
                end
            end
            TRR_CODE_REMOTE_TWO: begin
                if (idx_reg[7:1] == 7'h00) begin
                    word_sel = snap_reg[2];
                end
            end
            TRR_CODE_OFFSET: begin
                if (idx_reg[7:1] == 7'h00) begin
                    word_sel = offset_reg;
                end
            end
            default: word_sel = TRR_RESULT_RST;
        endcase
        // even index carries the low byte
        byte_sel = idx_reg[0] ? word_sel[15:8] :
            word_sel[7:0];
        reserved_code = code_reg >= TRR_CODE_RESV_LO &&
            code_reg <= TRR_CODE_RESV_HI;
    end

    // snapshot at command start so a read never mixes conversions
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            snap_reg[0] <= TRR_RESULT_RST;
            snap_reg[1] <= TRR_RESULT_RST;
            snap_reg[2] <= TRR_RESULT_RST;
        end else if (state_reg == TRR_DEV_IDLE && link.cmd_valid) begin
            snap_reg[0] <= result_reg[0];
            snap_reg[1] <= result_reg[1];
            snap_reg[2] <= result_reg[2];
        end
    end

    // transaction sequencer
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= TRR_DEV_IDLE;
            code_reg <= TRR_BYTE_RST;
            wr_left_reg <= TRR_BYTE_RST;
            rd_left_reg <= TRR_BYTE_RST;
            idx_reg <= TRR_BYTE_RST;
            low_byte_reg <= TRR_BYTE_RST;
            link.rd_valid <= 1'b0;
            link.rd_data <= TRR_BYTE_RST;
            link.done <= 1'b0;
            link.check_ok <= 1'b0;
        end else begin
            link.rd_valid <= 1'b0;
            link.done <= 1'b0;
            unique case (state_reg)
                TRR_DEV_IDLE: begin
                    if (link.cmd_valid) begin
                        code_reg <= link.cmd_code;
                        wr_left_reg <= link.wr_len;
                        rd_left_reg <= link.rd_len;
                        idx_reg <= TRR_BYTE_RST;
                        if (link.wr_len != 8'h00) begin
                            state_reg <= TRR_DEV_WRITE;
                        end else if (link.rd_len != 8'h00) begin
                            state_reg <= TRR_DEV_READ;
                        end else begin
                            state_reg <= TRR_DEV_DONE;
                        end
                    end
                end
                TRR_DEV_WRITE: begin
                    if (link.wr_valid) begin
                        if (idx_reg == 8'h00) begin
                            low_byte_reg <= link.wr_data;
                        end
                        idx_reg <= idx_reg + 8'h01;
                        wr_left_reg <= wr_left_reg - 8'h01;
                        if (wr_left_reg == 8'h01) begin
                            idx_reg <= TRR_BYTE_RST;
                            state_reg <= (rd_left_reg != 8'h00) ?
                                TRR_DEV_READ : TRR_DEV_DONE;
                        end
                    end
                end
                TRR_DEV_READ: begin
                    link.rd_valid <= 1'b1;
                    link.rd_data <= byte_sel;
                    idx_reg <= idx_reg + 8'h01;
                    rd_left_reg <= rd_left_reg - 8'h01;
                    if (rd_left_reg == 8'h01) begin
                        state_reg <= TRR_DEV_DONE;
                    end
                end
                TRR_DEV_DONE: begin
                    // codes 03..DF and others pass quietly
                    link.done <= 1'b1;
                    link.check_ok <= !reserved_code;
                    state_reg <= TRR_DEV_IDLE;
                end
                default: state_reg <= TRR_DEV_IDLE;
            endcase
        end
    end

endmodule // trr_device

// ---- core/trr_host.sv ----
`timescale 1ns/1ns
module trr_host
    import trr_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // link to the device
    trr_link_if.host link,
    // user request
    input wire logic req_valid,
    input wire logic [7:0] req_code,
    input wire logic [7:0] req_wr_len,
    input wire logic [7:0] req_rd_len,
    input wire logic [15:0] req_wdata,
    output logic req_ready,
    // user response, bytes little endian
    output logic resp_valid,
    output logic [47:0] resp_data,
    output logic resp_check_ok
);

    trr_host_state_type state_reg;
    logic [7:0] wr_left_reg;
    logic [7:0] widx_reg;
    logic [15:0] wdata_reg;
    logic [2:0] ridx_reg;
    logic [7:0] wbyte;

    // bytes past the second go out as zero
    always_comb begin
        wbyte = (widx_reg == 8'h00) ? wdata_reg[7:0] :
            (widx_reg == 8'h01) ? wdata_reg[15:8] :
            TRR_BYTE_RST;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= TRR_HOST_IDLE;
            wr_left_reg <= TRR_BYTE_RST;
            widx_reg <= TRR_BYTE_RST;
            wdata_reg <= TRR_RESULT_RST;
            ridx_reg <= 3'h0;
            req_ready <= 1'b0;
            resp_valid <= 1'b0;
            resp_data <= TRR_RESP_RST;
            resp_check_ok <= 1'b0;
            link.cmd_valid <= 1'b0;
            link.cmd_code <= TRR_BYTE_RST;
            link.wr_len <= TRR_BYTE_RST;
            link.rd_len <= TRR_BYTE_RST;
            link.wr_valid <= 1'b0;
            link.wr_data <= TRR_BYTE_RST;
        end else begin
            resp_valid <= 1'b0;
            link.cmd_valid <= 1'b0;
            unique case (state_reg)
                TRR_HOST_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        link.cmd_valid <= 1'b1;
                        link.cmd_code <= req_code;
                        link.wr_len <= req_wr_len;
                        link.rd_len <= req_rd_len;
                        wr_left_reg <= req_wr_len;
                        wdata_reg <= req_wdata;
                        widx_reg <= TRR_BYTE_RST;
                        ridx_reg <= 3'h0;
                        resp_data <= TRR_RESP_RST;
                        state_reg <= TRR_HOST_CMD;
                    end
                end
                TRR_HOST_CMD: begin
                    if (wr_left_reg != 8'h00) begin
                        link.wr_valid <= 1'b1;
                        link.wr_data <= wbyte;
                        widx_reg <= widx_reg + 8'h01;
                        wr_left_reg <= wr_left_reg - 8'h01;
                        state_reg <= TRR_HOST_WRITE;
                    end else begin
                        state_reg <= TRR_HOST_WAIT;
                    end
                end
                TRR_HOST_WRITE: begin
                    if (wr_left_reg != 8'h00) begin
                        link.wr_data <= wbyte;
                        widx_reg <= widx_reg + 8'h01;
                        wr_left_reg <= wr_left_reg - 8'h01;
                    end else begin
                        link.wr_valid <= 1'b0;
                        state_reg <= TRR_HOST_WAIT;
                    end
                end
                TRR_HOST_WAIT: begin
                    if (link.rd_valid && ridx_reg < 3'h6) begin
                        resp_data[ridx_reg*8 +: 8] <= link.rd_data;
                        ridx_reg <= ridx_reg + 3'h1;
                    end
                    if (link.done) begin
                        resp_valid <= 1'b1;
                        resp_check_ok <= link.check_ok;
                        state_reg <= TRR_HOST_IDLE;
                    end
                end
                default: state_reg <= TRR_HOST_IDLE;
            endcase
        end
    end

endmodule // trr_host

// ---- dv/trr_link_chk.sv ----
`timescale 1ns/1ns
module trr_link_chk (
    // clock and reset
    input logic mclk,
    input logic reset_n,
    // host to device
    input logic cmd_valid,
    input logic [7:0] cmd_code,
    input logic [7:0] wr_len,
    input logic [7:0] rd_len,
    input logic wr_valid,
    input logic [7:0] wr_data,
    // device to host
    input logic rd_valid,
    input logic [7:0] rd_data,
    input logic done,
    input logic check_ok
);
    logic [7:0] rd_cnt_reg;
    logic [7:0] rd_len_reg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    // read bytes seen so far in the current command
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_cnt_reg <= 8'h00;
        end else if (cmd_valid) begin
            rd_cnt_reg <= 8'h00;
        end else if (rd_valid) begin
            rd_cnt_reg <= rd_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_len_reg <= 8'h00;
        end else if (cmd_valid) begin
            rd_len_reg <= rd_len;
        end
    end

    sequence rd4_s;
        !rd_valid ##1 rd_valid [*4] ##1 (done && !rd_valid);
    endsequence

    // the device needs one turn-around cycle after the last write byte
    sequence wr2_s;
        wr_valid [*2] ##1 !wr_valid ##1 (done && !wr_valid);
    endsequence

    read_burst_a: assert property (
        cmd_valid && wr_len == 8'h00 && rd_len == 8'h04 |=> rd4_s)
        else $error("four byte read burst malformed");
    write_burst_a: assert property (
        cmd_valid && wr_len == 8'h02 && rd_len == 8'h00 |=> wr2_s)
        else $error("two byte write burst malformed");
    read_count_a: assert property (
        done |-> rd_cnt_reg == rd_len_reg)
        else $error("read byte count differs from read length");
    burst_end_a: assert property (
        $fell(rd_valid) |-> done)
        else $error("read burst not closed by done");
    resv_check_a: assert property (
        done && cmd_code >= 8'hE2 && cmd_code <= 8'hEE |-> !check_ok)
        else $error("reserved code gave a valid check");
    ignore_check_a: assert property (
        done && cmd_code >= 8'h03 && cmd_code <= 8'hDF |-> check_ok)
        else $error("ignored code gave a bad check");
    zero_fill_a: assert property (
        rd_valid && rd_cnt_reg >= 8'h02
        && cmd_code inside {8'h01, 8'h02, 8'hE0} |-> rd_data == 8'h00)
        else $error("byte past single word not zero");
    offset_gran_a: assert property (
        rd_valid && rd_cnt_reg == 8'h00 && cmd_code == 8'hE0
        |-> rd_data[3:0] == 4'h0)
        else $error("offset low byte finer than quarter degree");
endmodule // trr_link_chk

// ---- dv/testbench.sv ----
`timescale 1ns/1ns
module testbench
    import trr_pkg::*;
;
    localparam int LOC_CYC = 20;
    localparam int REM_CYC = 40;
    logic mclk;
    logic reset_n;
    logic [15:0] local_meas;
    logic [15:0] remote_one_meas;
    logic [15:0] remote_two_meas;
    logic remote_one_fault;
    logic remote_two_fault;
    logic remote_two_present;
    logic [1:0] chan_seen;
    logic [1:0] conv_channel;
    logic conv_done;
    logic req_valid;
    logic [7:0] req_code;
    logic [7:0] req_wr_len;
    logic [7:0] req_rd_len;
    logic [15:0] req_wdata;
    logic req_ready;
    logic resp_valid;
    logic [47:0] resp_data;
    logic resp_check_ok;
    logic [47:0] exp_q[$];
    logic ok_q[$];
    logic [15:0] ofs_tab[5] = '{16'h0140, 16'hFF00, 16'h3000, 16'h0047,
        16'hC000};
    logic [15:0] eff_tab[5] = '{16'h0140, 16'hFF00, 16'h2000, 16'h0040,
        16'hE000};
    int fails;
    int n_checks;
    int n;
    integer seed = 32'hA5EAA41F;

    trr_link_if link ();
    trr_device #(.LOCAL_CONV_CYC(LOC_CYC), .REMOTE_CONV_CYC(REM_CYC))
        u_trr_device (.mclk(mclk), .reset_n(reset_n), .link(link),
        .local_meas(local_meas), .remote_one_meas(remote_one_meas),
        .remote_two_meas(remote_two_meas),
        .remote_one_fault(remote_one_fault),
        .remote_two_fault(remote_two_fault),
        .remote_two_present(remote_two_present),
        .conv_channel(conv_channel), .conv_done(conv_done));
    trr_host u_trr_host (.mclk(mclk), .reset_n(reset_n), .link(link),
        .req_valid(req_valid), .req_code(req_code),
        .req_wr_len(req_wr_len), .req_rd_len(req_rd_len),
        .req_wdata(req_wdata), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp_data(resp_data),
        .resp_check_ok(resp_check_ok));
    trr_link_chk u_trr_link_chk (.mclk(mclk), .reset_n(reset_n),
        .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
        .wr_len(link.wr_len), .rd_len(link.rd_len),
        .wr_valid(link.wr_valid), .wr_data(link.wr_data),
        .rd_valid(link.rd_valid), .rd_data(link.rd_data),
        .done(link.done), .check_ok(link.check_ok));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic tick;
        @(posedge mclk);
        #1;
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp48(string what, logic [47:0] e, logic [47:0] s);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic cmp1(string what, logic e, logic s);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s expected %b seen %b", what, e, s);
        end
    endtask

    // one whole request; expectation noted before it is issued
    task automatic xfer(logic [7:0] code, logic [7:0] wl, logic [7:0] rl,
        logic [15:0] wd, logic [47:0] ed, logic eok);
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 200) begin
            tick;
            k++;
        end
        if (k >= 200) begin
            fails++;
        end
        exp_q.push_back(ed);
        ok_q.push_back(eok);
        req_code = code;
        req_wr_len = wl;
        req_rd_len = rl;
        req_wdata = wd;
        req_valid = 1'b1;
        tick;
        req_valid = 1'b0;
        k = 0;
        while (resp_valid !== 1'b1 && k < 200) begin
            tick;
            k++;
        end
        if (k >= 200) begin
            fails++;
        end
        tick;
    endtask

    // next stored result; a missing one counts as a mismatch
    task automatic wait_store;
        int k;
        k = 0;
        tick;
        while (conv_done !== 1'b1 && k < 200) begin
            tick;
            k++;
        end
        if (k >= 200) begin
            fails++;
        end
    endtask

    // two full rounds, so every channel holds the current inputs
    task automatic settle;
        repeat (6) wait_store;
    endtask

    // kept to +-32 degrees so adding any offset never saturates
    function automatic logic [15:0] rnd_meas();
        logic [31:0] r;
        r = $random(seed);
        return {{4{r[11]}}, r[11:0]};
    endfunction

    always @(posedge mclk) begin
        if (resp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("BAD response expected none seen %h", resp_data);
            end else begin
                cmp48("resp_data", exp_q.pop_front(), resp_data);
                cmp1("check_ok", ok_q.pop_front(), resp_check_ok);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        wrap_up;
    end

    initial begin
        reset_n = 1'b0;
        req_valid = 1'b0;
        req_code = 8'h00;
        req_wr_len = 8'h00;
        req_rd_len = 8'h00;
        req_wdata = 16'h0000;
        local_meas = 16'h0040;
        remote_one_meas = 16'hFFC0;
        remote_two_meas = 16'h1F40;
        remote_one_fault = 1'b0;
        remote_two_fault = 1'b0;
        remote_two_present = 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        n = 0;
        while (conv_done !== 1'b1 && n < 100) begin
            tick;
            n++;
        end
        cmp48("first store", 48'(LOC_CYC), 48'(n));
        n = 0;
        tick;
        n++;
        while (conv_done !== 1'b1 && n < 100) begin
            tick;
            n++;
        end
        cmp48("second store", 48'(REM_CYC), 48'(n));
        settle;
        xfer(TRR_CODE_LOCAL, 8'h00, 8'h02, 16'h0000, 48'h0040, 1'b1);
        xfer(TRR_CODE_REMOTE_ONE, 8'h00, 8'h04, 16'h0000, 48'hFFC0,
            1'b1);
        xfer(TRR_CODE_REMOTE_TWO, 8'h00, 8'h02, 16'h0000, 48'h1F40,
            1'b1);
        xfer(TRR_CODE_LOCAL, 8'h00, TRR_ALL_TEMPS_LEN, 16'h0000,
            48'hFFC00040, 1'b1);
        for (int i = 0; i < 5; i++) begin
            xfer(TRR_CODE_OFFSET, 8'h02, 8'h00, ofs_tab[i], 48'h0,
                1'b1);
            xfer(TRR_CODE_OFFSET, 8'h00, 8'h02, 16'h0000, {32'h0, eff_tab[i]},
                1'b1);
            local_meas = rnd_meas();
            remote_one_meas = rnd_meas();
            remote_two_meas = rnd_meas();
            settle;
            xfer(TRR_CODE_LOCAL, 8'h00, 8'h06, 16'h0000,
                {remote_two_meas + eff_tab[i], remote_one_meas + eff_tab[i],
                local_meas + eff_tab[i]}, 1'b1);
        end
        xfer(8'hE5, 8'h02, 8'h00, 16'h1230, 48'h0, 1'b0);
        xfer(8'h05, 8'h02, 8'h00, 16'h1230, 48'h0, 1'b1);
        xfer(8'hE5, 8'h00, 8'h02, 16'h0000, 48'h0, 1'b0);
        xfer(TRR_CODE_OFFSET, 8'h00, 8'h02, 16'h0000, 48'hE000,
            1'b1);
        remote_one_fault = 1'b1;
        settle;
        xfer(TRR_CODE_REMOTE_ONE, 8'h00, 8'h02, 16'h0000,
            {32'h0, TRR_FAULT_CODE}, 1'b1);
        remote_one_fault = 1'b0;
        remote_two_fault = 1'b1;
        settle;
        xfer(TRR_CODE_LOCAL, 8'h00, 8'h06, 16'h0000, {TRR_FAULT_CODE,
            remote_one_meas + 16'hE000, local_meas + 16'hE000},
            1'b1);
        // channel two unfitted: round robin alternates local and remote one
        remote_two_present = 1'b0;
        wait_store;
        for (int j = 0; j < 4; j++) begin
            chan_seen = conv_channel;
            wait_store;
            cmp48("next channel", (chan_seen == TRR_CHAN_LOCAL) ?
                48'(TRR_CHAN_REMOTE_ONE) : 48'(TRR_CHAN_LOCAL),
                48'(conv_channel));
        end
        wrap_up;
    end
endmodule // testbench
